// [include/sas_pkg.sv]
// Constants and types for the servo alarm supervisor.
// Assumes a single 40 MHz clock domain.
package sas_pkg;
	localparam int SAS_CLK_HZ = 40_000_000;
	localparam logic [3:0] SAS_ADAPT_DISABLE = 4'h2;
	localparam logic [3:0] SAS_CODE_OUT_ENABLE = 4'h1;
	localparam logic SAS_FORCED_DECEL_RESET = 1'b1;
	localparam logic [7:0] SAS_PARAM_ERR_NUM = 8'h37;
	localparam logic [7:0] SAS_TOUGH_WARN_NUM = 8'hF0;
	localparam logic [7:0] SAS_WARN_FIRST = 8'h90;
	localparam logic [7:0] SAS_WARN_LAST = 8'hF3;
	localparam int SAS_DECEL_TIME_US = 100;
	localparam int SAS_DECEL_CYCLES = (SAS_DECEL_TIME_US * (SAS_CLK_HZ / 1_000_000));
	localparam int SAS_HIST_DEPTH = 8;
	typedef enum logic [1:0] {
		SAS_STOP_SD,
		SAS_STOP_DB,
		SAS_STOP_EDB
	} sas_stop_t;
	typedef enum {
		SAS_RUN,
		SAS_DECEL,
		SAS_BRAKE
	} sas_state_t;
	localparam logic [1:0] SAS_CLR_RESET = 2'b01;
	localparam logic [1:0] SAS_CLR_POWER = 2'b10;
endpackage

// [rtl/sas_mode_gate.sv]
// Control mode selection and function gating.
// Assumes settings are static levels from the parameter store.
`timescale 1ns/1ps
module sas_mode_gate
	import sas_pkg::*;
(
	input wire logic [3:0] adaptive_mode_select,
	input wire logic forced_decel_enable,
	input wire logic vib_supp1_enable,
	input wire logic vib_supp2_enable,
	input wire logic overshoot_comp_enable,
	output logic pid_only,
	output logic vib_supp1_active,
	output logic vib_supp2_active,
	output logic overshoot_comp_active,
	output logic param_error
);
	always_comb begin
		pid_only = (adaptive_mode_select == SAS_ADAPT_DISABLE);
		param_error = pid_only && forced_decel_enable;
		vib_supp1_active = vib_supp1_enable && !pid_only;
		vib_supp2_active = vib_supp2_enable && !pid_only;
		overshoot_comp_active = overshoot_comp_enable && !pid_only;
	end
endmodule

// [rtl/sas_history.sv]
// Alarm history record, newest entry at index 0.
// Assumes log_valid is a one-cycle pulse.
`timescale 1ns/1ps
module sas_history
	import sas_pkg::*;
#(
	parameter int DEPTH = SAS_HIST_DEPTH
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic log_valid,
	input wire logic [7:0] log_num,
	input wire logic [$clog2(DEPTH)-1:0] rd_index,
	output logic [7:0] rd_num
);
	if (DEPTH < 2 || (1 << $clog2(DEPTH)) != DEPTH) begin : g_depth_chk
		$error("DEPTH must be a power of two, at least 2");
	end
	typedef struct packed {
		logic [DEPTH-1:0][7:0] entry;
		logic [7:0] rd;
	} sas_hist_t;
	sas_hist_t s_q, s_d;
	always_comb begin
		s_d = s_q;
		if (log_valid) begin
			for (int i = DEPTH - 1; i > 0; i--) begin
				s_d.entry[i] = s_q.entry[i-1];
			end
			s_d.entry[0] = log_num;
		end
		s_d.rd = s_q.entry[rd_index];
	end
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end
	assign rd_num = s_q.rd;
endmodule

// [rtl/sas_supervisor.sv]
// Servo alarm supervisor top: mode gating, stop sequencing, alarm latch,
// history, alarm code outputs. Assumes all inputs synchronous to mclk.
// Summary of operation
// - Adaptive mode at disable value selects PID using three loop gain settings.
// - PID-only with forced decel enabled raises parameter error alarm.
// - Forced decel setting defaults enabled; host clears it before PID-only.
// - PID-only keeps both vibration suppression controls inactive.
// - PID-only keeps overshoot compensation inactive.
// - Parameter error and warnings except tough drive not recorded in history.
// - Any active alarm deasserts the malfunction output.
// - Decel-then-brake class: forced deceleration first, then dynamic brake.
// - Brake classes apply the brake at once, skipping deceleration.
// - Alarm clears only after cause gone, by a permitted method.
// - Warnings cancel automatically once their cause is gone.
// - Clear input, panel set press with alarm view selected, or tool command each reset alarms.
// - Power cycle clears alarms; display blanked before power returns.
// - Code output select at enable puts alarm code on three bits.
// - Warnings 90 to F3 drive no alarm code.
// - No active alarm means no alarm code driven.
// - Active alarm or warning number shown on the display.
`timescale 1ns/1ps
module sas_supervisor
	import sas_pkg::*;
#(
	parameter int DECEL_CYCLES = SAS_DECEL_CYCLES,
	parameter int HIST_DEPTH = SAS_HIST_DEPTH
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic [3:0] adaptive_mode_select,
	input wire logic forced_decel_enable,
	input wire logic [3:0] alarm_code_output_select,
	input wire logic [7:0] position_loop_gain,
	input wire logic [7:0] speed_loop_gain,
	input wire logic [7:0] speed_integral_comp,
	input wire logic vib_supp1_enable,
	input wire logic vib_supp2_enable,
	input wire logic overshoot_comp_enable,
	input wire logic fault_detect,
	input wire logic [7:0] fault_num,
	input wire logic [2:0] fault_code,
	input wire logic [1:0] fault_stop,
	input wire logic [1:0] fault_clear_ok,
	input wire logic alarm_clear_input,
	input wire logic panel_set_press,
	input wire logic panel_alarm_view,
	input wire logic tool_alarm_reset,
	input wire logic power_down,
	input wire logic servo_on_input,
	input wire logic [$clog2(HIST_DEPTH)-1:0] hist_rd_index,
	output logic [7:0] hist_rd_num,
	output logic pid_only,
	output logic [7:0] active_position_gain,
	output logic [7:0] active_speed_gain,
	output logic [7:0] active_integral_comp,
	output logic vib_supp1_active,
	output logic vib_supp2_active,
	output logic overshoot_comp_active,
	output logic malfunction_output,
	output logic forced_decel_active,
	output logic brake_active,
	output logic [2:0] alarm_code,
	output logic display_on,
	output logic [7:0] display_num,
	output logic display_valid
);
	if (DECEL_CYCLES < 1) begin : g_decel_chk
		$error("DECEL_CYCLES must be at least 1");
	end
	if (HIST_DEPTH < 2 || (1 << $clog2(HIST_DEPTH)) != HIST_DEPTH) begin : g_depth_chk
		$error("HIST_DEPTH must be a power of two, at least 2");
	end

	typedef struct packed {
		logic alarm;
		logic [7:0] alarm_num;
		logic [2:0] alarm_code;
		logic [1:0] clear_ok;
		logic has_code;
		logic warn;
		logic [7:0] warn_num;
		logic fault_prev;
		logic log_valid;
		logic [7:0] log_num;
		sas_state_t state;
		logic [31:0] decel_cnt;
		logic [7:0] pos_gain;
		logic [7:0] spd_gain;
		logic [7:0] int_comp;
		logic [2:0] code_out;
		logic [7:0] disp_num;
		logic disp_valid;
		logic disp_on;
	} sas_top_t;

	sas_top_t s_q, s_d;
	logic param_error;
	logic pid_mode;
	logic is_warn;
	logic is_alarm_event;
	logic cause_present;
	logic reset_req;

	sas_mode_gate u_mode_gate (
		.adaptive_mode_select(adaptive_mode_select),
		.forced_decel_enable(forced_decel_enable),
		.vib_supp1_enable(vib_supp1_enable),
		.vib_supp2_enable(vib_supp2_enable),
		.overshoot_comp_enable(overshoot_comp_enable),
		.pid_only(pid_mode),
		.vib_supp1_active(vib_supp1_active),
		.vib_supp2_active(vib_supp2_active),
		.overshoot_comp_active(overshoot_comp_active),
		.param_error(param_error)
	);

	sas_history #(
		.DEPTH(HIST_DEPTH)
	) u_history (
		.mclk(mclk),
		.rst(rst),
		.log_valid(s_q.log_valid),
		.log_num(s_q.log_num),
		.rd_index(hist_rd_index),
		.rd_num(hist_rd_num)
	);

	always_comb begin
		is_warn = (fault_num >= SAS_WARN_FIRST) && (fault_num <= SAS_WARN_LAST);
		is_alarm_event = fault_detect && !is_warn;
		// Cause of the latched alarm still present
		cause_present = (s_q.alarm_num == SAS_PARAM_ERR_NUM) ? param_error
			: (fault_detect && fault_num == s_q.alarm_num);
		reset_req = alarm_clear_input || (panel_set_press && panel_alarm_view) || tool_alarm_reset;
	end

	always_comb begin
		s_d = s_q;
		s_d.log_valid = 1'b0;
		s_d.fault_prev = fault_detect;
		// Warnings follow their cause directly
		s_d.warn = fault_detect && is_warn;
		s_d.warn_num = fault_num;
		if (!s_q.alarm) begin
			if (param_error) begin
				s_d.alarm = 1'b1;
				s_d.alarm_num = SAS_PARAM_ERR_NUM;
				s_d.has_code = 1'b1;
				s_d.alarm_code = 3'h0;
				s_d.clear_ok = SAS_CLR_RESET | SAS_CLR_POWER;
				if (s_q.state == SAS_RUN) begin
					s_d.state = SAS_BRAKE;
				end
			end else if (is_alarm_event) begin
				s_d.alarm = 1'b1;
				s_d.alarm_num = fault_num;
				s_d.alarm_code = fault_code;
				s_d.has_code = 1'b1;
				s_d.clear_ok = fault_clear_ok;
				if (s_q.state == SAS_RUN) begin
					if (fault_stop == 2'(SAS_STOP_SD) && forced_decel_enable) begin
						s_d.state = SAS_DECEL;
						s_d.decel_cnt = '0;
					end else begin
						s_d.state = SAS_BRAKE;
					end
				end
			end
		end else if (!cause_present && reset_req && s_q.clear_ok[0]) begin
			s_d.alarm = 1'b0;
			s_d.has_code = 1'b0;
			s_d.state = SAS_RUN;
		end
		// History entry on a new event, filtered
		if (fault_detect && !s_q.fault_prev) begin
			if (!is_warn || fault_num == SAS_TOUGH_WARN_NUM) begin
				s_d.log_valid = 1'b1;
				s_d.log_num = fault_num;
			end
		end
		// Warning stop when no alarm is held
		if (!s_q.alarm && fault_detect && is_warn && s_q.state == SAS_RUN && fault_num != SAS_TOUGH_WARN_NUM) begin
			if (fault_stop == 2'(SAS_STOP_SD) && forced_decel_enable) begin
				s_d.state = SAS_DECEL;
				s_d.decel_cnt = '0;
			end else if (fault_stop != 2'(SAS_STOP_SD)) begin
				s_d.state = SAS_BRAKE;
			end
		end
		case (s_q.state)
			SAS_RUN: begin
			end
			SAS_DECEL: begin
				if (s_q.decel_cnt == 32'(DECEL_CYCLES - 1)) begin
					s_d.state = SAS_BRAKE;
				end else begin
					s_d.decel_cnt = s_q.decel_cnt + 32'h1;
				end
			end
			SAS_BRAKE: begin
				if (!s_d.alarm && !s_d.warn) begin
					s_d.state = SAS_RUN;
				end
			end
			default: begin
				s_d.state = SAS_RUN;
			end
		endcase
		// Gains used by the PID loop
		if (pid_mode) begin
			s_d.pos_gain = position_loop_gain;
			s_d.spd_gain = speed_loop_gain;
			s_d.int_comp = speed_integral_comp;
		end else begin
			s_d.pos_gain = 8'h00;
			s_d.spd_gain = 8'h00;
			s_d.int_comp = 8'h00;
		end
		// Alarm code bits
		if (s_d.alarm && s_d.has_code && alarm_code_output_select == SAS_CODE_OUT_ENABLE) begin
			s_d.code_out = s_d.alarm_code;
		end else begin
			s_d.code_out = 3'h0;
		end
		// Display
		s_d.disp_on = !power_down;
		if (s_d.alarm) begin
			s_d.disp_num = s_d.alarm_num;
			s_d.disp_valid = 1'b1;
		end else if (s_d.warn) begin
			s_d.disp_num = s_d.warn_num;
			s_d.disp_valid = 1'b1;
		end else begin
			s_d.disp_num = 8'h00;
			s_d.disp_valid = 1'b0;
		end
		if (power_down) begin
			s_d.disp_valid = 1'b0;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			// Power-up clears any alarm
			s_q <= '0;
			s_q.state <= SAS_RUN;
		end else begin
			s_q <= s_d;
		end
	end

	always_comb begin
		pid_only = pid_mode;
		active_position_gain = s_q.pos_gain;
		active_speed_gain = s_q.spd_gain;
		active_integral_comp = s_q.int_comp;
		malfunction_output = !s_q.alarm;
		forced_decel_active = (s_q.state == SAS_DECEL);
		brake_active = (s_q.state == SAS_BRAKE);
		alarm_code = s_q.code_out;
		display_on = s_q.disp_on;
		display_num = s_q.disp_num;
		display_valid = s_q.disp_valid;
	end
endmodule

// [sim/sas_host_model.sv]
// Host controller model: drops servo-on and requests alarm clears.
// Assumes the bench removes the fault cause itself.
`timescale 1ns/1ps
module sas_host_model (
	input wire logic mclk,
	input wire logic malfunction_output,
	input wire logic clear_go,
	input wire logic [3:0] wait_cycles,
	output logic alarm_clear_input,
	output logic servo_on_input
);
	initial begin
		alarm_clear_input = 1'b0;
		servo_on_input = 1'b1;
		forever begin
			@(posedge mclk);
			#2;
			servo_on_input = malfunction_output;
			if (clear_go && !malfunction_output) begin
				repeat (wait_cycles) @(posedge mclk);
				#2 alarm_clear_input = 1'b1;
				@(posedge mclk);
				#2 alarm_clear_input = 1'b0;
			end
		end
	end
endmodule

// [sim/sas_supervisor_asserts.sv]
// Checker on the supervisor top ports.
// Bound from the testbench; single mclk domain.
`timescale 1ns/1ps
module sas_supervisor_asserts
	import sas_pkg::*;
#(
	parameter int DECEL_CYCLES = SAS_DECEL_CYCLES
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic [3:0] adaptive_mode_select,
	input wire logic forced_decel_enable,
	input wire logic fault_detect,
	input wire logic [7:0] fault_num,
	input wire logic [1:0] fault_stop,
	input wire logic pid_only,
	input wire logic vib_supp1_active,
	input wire logic vib_supp2_active,
	input wire logic overshoot_comp_active,
	input wire logic malfunction_output,
	input wire logic forced_decel_active,
	input wire logic brake_active,
	input wire logic [2:0] alarm_code
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	int decel_q;
	logic warn;
	assign warn = fault_num >= SAS_WARN_FIRST && fault_num <= SAS_WARN_LAST;
	always_ff @(posedge mclk or posedge rst) begin
		if (rst)
			decel_q <= 0;
		else if (forced_decel_active)
			decel_q <= decel_q + 1;
		else if (!brake_active)
			decel_q <= 0;
	end
	mode_sel_a: assert property (pid_only == (adaptive_mode_select == SAS_ADAPT_DISABLE))
		else $error("pid select wrong");
	gate_off_a: assert property (pid_only |-> !vib_supp1_active && !vib_supp2_active && !overshoot_comp_active)
		else $error("gated function active");
	param_err_a: assert property (pid_only && forced_decel_enable && malfunction_output |=> !malfunction_output)
		else $error("no parameter error");
	alarm_set_a: assert property (malfunction_output && fault_detect && !warn |=> !malfunction_output)
		else $error("alarm did not drop malfunction");
	warn_code_a: assert property (malfunction_output && fault_detect && warn && !pid_only |=> alarm_code == 3'h0)
		else $error("warning drove a code");
	idle_code_a: assert property (malfunction_output |-> alarm_code == 3'h0)
		else $error("code without alarm");
	hold_code_a: assert property (!malfunction_output && $past(!malfunction_output) |-> $stable(alarm_code))
		else $error("code moved during alarm");
	cause_hold_a: assert property (!malfunction_output && fault_detect |=> !malfunction_output)
		else $error("cleared with cause present");
	brake_now_a: assert property ($fell(malfunction_output) && $past(fault_detect) && $past(fault_stop) != SAS_STOP_SD
		|-> brake_active && !forced_decel_active)
		else $error("brake class decelerated");
	decel_len_a: assert property ($rose(brake_active) && $past(forced_decel_active) |-> decel_q == DECEL_CYCLES)
		else $error("decel length wrong");
	cover property ($rose(brake_active) && decel_q != 0);
	cover property ($fell(malfunction_output) && pid_only);
	cover property ($rose(malfunction_output));
endmodule

// [sim/testbench.sv]
// Self-checking bench for the supervisor with a host model.
// Expected alarm transitions queued; a monitor compares them.
`timescale 1ns/1ps
module testbench;
	import sas_pkg::*;
	localparam int DECEL = 4;
	logic mclk = 1'b0, rst = 1'b1;
	logic [3:0] adaptive_mode_select = 4'h0, alarm_code_output_select = 4'h1, wait_cycles = 4'h0;
	logic forced_decel_enable = 1'b1, vib_supp1_enable = 1'b1, vib_supp2_enable = 1'b1, overshoot_comp_enable = 1'b1;
	logic fault_detect = 1'b0, panel_set_press = 1'b0, panel_alarm_view = 1'b0, tool_alarm_reset = 1'b0, clear_go = 1'b0;
	logic [7:0] position_loop_gain = 8'h00, speed_loop_gain = 8'h00, speed_integral_comp = 8'h00, fault_num = 8'h00;
	logic [2:0] fault_code = 3'h0, hist_rd_index = 3'h0, alarm_code;
	logic [1:0] fault_stop = 2'h0, fault_clear_ok = 2'h1;
	logic alarm_clear_input, servo_on_input, pid_only, vib_supp1_active, vib_supp2_active, overshoot_comp_active;
	logic malfunction_output, forced_decel_active, brake_active, display_on, display_valid, last_malf = 1'b1;
	logic [7:0] hist_rd_num, active_position_gain, active_speed_gain, active_integral_comp, display_num;
	logic [7:0] nums [3];
	logic [3:0] exp_q [$];
	int err_count = 0, num_checks = 0, cyc = 0, i, j;
	logic [31:0] seed = 32'h093C;
	logic power_down = 1'b0;
	sas_supervisor #(.DECEL_CYCLES(DECEL), .HIST_DEPTH(8)) DUT (.mclk, .rst, .adaptive_mode_select,
		.forced_decel_enable, .alarm_code_output_select, .position_loop_gain, .speed_loop_gain, .speed_integral_comp,
		.vib_supp1_enable, .vib_supp2_enable, .overshoot_comp_enable, .fault_detect, .fault_num, .fault_code,
		.fault_stop, .fault_clear_ok, .alarm_clear_input, .panel_set_press, .panel_alarm_view, .tool_alarm_reset,
		.power_down, .servo_on_input, .hist_rd_index, .hist_rd_num, .pid_only, .active_position_gain,
		.active_speed_gain, .active_integral_comp, .vib_supp1_active, .vib_supp2_active, .overshoot_comp_active,
		.malfunction_output, .forced_decel_active, .brake_active, .alarm_code, .display_on, .display_num,
		.display_valid);
	sas_host_model HOST (.mclk, .malfunction_output, .clear_go, .wait_cycles, .alarm_clear_input, .servo_on_input);
	always #12.5 mclk = ~mclk;
	task automatic close_out;
		if (err_count == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
		num_checks++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
		#2;
	endtask
	task automatic wait_malf;
		int k;
		k = 0;
		while (malfunction_output !== 1'b1 && k < 60) begin
			tick(1);
			k++;
		end
	endtask
	task automatic press(input int m, input logic v);
		case (m)
			0: clear_go = v;
			1: {panel_set_press, panel_alarm_view} = {v, v};
			default: tool_alarm_reset = v;
		endcase
	endtask
	always @(posedge mclk) begin
		cyc++;
		if (cyc > 3000) begin
			err_count++;
			close_out();
		end
	end
	always @(posedge mclk) begin
		#1;
		if (malfunction_output !== last_malf) begin
			last_malf = malfunction_output;
			if (exp_q.size() == 0)
				chk({4'h0, malfunction_output, alarm_code}, 8'hFF, "unexpected alarm change");
			else
				chk({4'h0, malfunction_output, alarm_code}, {4'h0, exp_q.pop_front()}, "alarm state");
		end
	end
	initial begin
		tick(5);
		rst = 1'b0;
		tick(1);
		chk({malfunction_output, alarm_code, display_on}, 8'h11, "reset state");
		for (i = 0; i < 3; i++) begin
			nums[i] = 8'h40 + ($random(seed) & 8'h3F);
			wait_cycles = $random(seed) & 4'h7;
			fault_clear_ok = {$random(seed) & 1'b1, 1'b1};
			{speed_integral_comp, speed_loop_gain, position_loop_gain, fault_code} = $random(seed);
			alarm_code_output_select = (i == 2) ? 4'h0 : SAS_CODE_OUT_ENABLE;
			{fault_num, fault_stop, fault_detect} = {nums[i], i[1:0], 1'b1};
			exp_q.push_back({1'b0, (i == 2) ? 3'h0 : fault_code});
			tick(2);
			chk(forced_decel_active, i == 0, "decel first");
			chk(display_num, nums[i], "display number");
			press(i, 1'b1);
			tick(DECEL + 4);
			chk({malfunction_output, brake_active}, 8'h01, "held and braking");
			fault_detect = 1'b0;
			exp_q.push_back(4'h8);
			wait_malf();
			chk(brake_active, 1'b0, "brake released");
			press(i, 1'b0);
			tick(2);
		end
		fault_num = SAS_WARN_FIRST + ($random(seed) & 8'h3F);
		fault_detect = 1'b1;
		tick(3);
		chk({malfunction_output, alarm_code, display_valid}, 8'h11, "warning");
		chk(display_num, fault_num, "warning number");
		power_down = 1'b1;
		{vib_supp1_enable, vib_supp2_enable, overshoot_comp_enable} = $random(seed);
		tick(2);
		chk({display_on, display_valid}, 8'h00, "display blank on power down");
		chk({vib_supp1_active, vib_supp2_active, overshoot_comp_active},
			{vib_supp1_enable, vib_supp2_enable, overshoot_comp_enable}, "functions outside pid");
		chk(active_position_gain | active_speed_gain | active_integral_comp, 8'h00, "gains outside pid");
		power_down = 1'b0;
		fault_detect = 1'b0;
		tick(3);
		chk(display_valid, 1'b0, "warning cancel");
		{vib_supp1_enable, vib_supp2_enable, overshoot_comp_enable} = 3'h7;
		exp_q.push_back(4'h0);
		adaptive_mode_select = SAS_ADAPT_DISABLE;
		tick(3);
		chk({pid_only, vib_supp1_active, vib_supp2_active, overshoot_comp_active}, 8'h08, "pid gating");
		chk(active_position_gain, position_loop_gain, "pid gain");
		chk(active_speed_gain, speed_loop_gain, "pid speed gain");
		chk(active_integral_comp, speed_integral_comp, "pid integral comp");
		forced_decel_enable = 1'b0;
		tool_alarm_reset = 1'b1;
		exp_q.push_back(4'h8);
		wait_malf();
		tool_alarm_reset = 1'b0;
		for (j = 0; j < 3; j++) begin
			hist_rd_index = j[2:0];
			tick(2);
			chk(hist_rd_num, nums[2 - j], "history");
		end
		{fault_num, fault_stop, fault_detect} = {nums[0], 2'h1, 1'b1};
		fault_clear_ok = 2'h2;
		exp_q.push_back(4'h0);
		tick(3);
		fault_detect = 1'b0;
		tool_alarm_reset = 1'b1;
		tick(2);
		chk(malfunction_output, 1'b0, "reset refused for power-only alarm");
		tool_alarm_reset = 1'b0;
		rst = 1'b1;
		exp_q.push_back(4'h8);
		tick(2);
		chk(display_on, 1'b0, "display blank");
		rst = 1'b0;
		tick(3);
		chk(exp_q.size(), 8'h00, "queue drained");
		close_out();
	end
endmodule
bind sas_supervisor sas_supervisor_asserts #(.DECEL_CYCLES(DECEL_CYCLES)) u_chk (.mclk, .rst, .adaptive_mode_select,
	.forced_decel_enable, .fault_detect, .fault_num, .fault_stop, .pid_only, .vib_supp1_active, .vib_supp2_active,
	.overshoot_comp_active, .malfunction_output, .forced_decel_active, .brake_active, .alarm_code);
